// ---- rtl/mcp_pkg.sv ----
// Purpose: Shared constants for the memory-control, chip-select and serial pin ports
// Assumes: 8-bit register port with byte offsets as below
// Notes:   Function, direction and open-drain registers are write-only
package mcp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register port
    localparam int        ADDR_W      = 8;
    localparam int        DATA_W      = 8;
    localparam logic [7:0] BC_DATA_OFS = 8'h1c;
    localparam logic [7:0] BC_DIR_OFS  = 8'h1e;
    localparam logic [7:0] BC_FUNC_OFS = 8'h1f;
    localparam logic [7:0] CS_DATA_OFS = 8'h20;
    localparam logic [7:0] CS_FUNC_OFS = 8'h23;
    localparam logic [7:0] SP_DATA_OFS = 8'h24;
    localparam logic [7:0] SP_ODE_OFS  = 8'h25;
    localparam logic [7:0] SP_DIR_OFS  = 8'h26;
    localparam logic [7:0] SP_FUNC_OFS = 8'h27;

    ////////////////////////////////////////////////////////////////////////////
    // Port widths
    localparam int BC_W   = 7;
    localparam int BC_O_W = 6;
    localparam int CS_W   = 4;
    localparam int SP_W   = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Bus-control function bit positions
    localparam int BC_RD_BIT   = 0;
    localparam int BC_WLL_BIT  = 1;
    localparam int BC_WLU_BIT  = 2;
    localparam int BC_RSVD_BIT = 3;
    localparam int BC_CLK_BIT  = 4;
    localparam int BC_RW_BIT   = 5;
    localparam int BC_WAIT_BIT = 6;

    // Serial function / open-drain bit positions
    localparam int SP_SCK_BIT = 0;
    localparam int SP_SDA_BIT = 1;
    localparam int SP_SCL_BIT = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [6:0] BC_LATCH_RST = 7'h3f;
    localparam logic [6:0] BC_FUNC_RST  = 7'h01;
    localparam logic [6:0] BC_OUT_ONLY  = 7'h3f;
    localparam logic [3:0] CS_LATCH_RST = 4'hb;
    localparam logic [3:0] CS_FUNC_RST  = 4'h0;
    localparam logic [2:0] SP_LATCH_RST = 3'h7;
    localparam logic [2:0] SP_DIR_RST   = 3'h0;
    localparam logic [2:0] SP_FUNC_RST  = 3'h0;
    localparam logic [2:0] SP_ODE_MASK  = 3'h6;

    ////////////////////////////////////////////////////////////////////////////
    // Boot strap decode
    localparam logic [1:0] BOOT_MODE_A = 2'h1;
    localparam logic [1:0] BOOT_MODE_B = 2'h2;
    localparam logic [1:0] STRAP_WAIT  = 2'h2;

endpackage

// ---- rtl/mcp_sync.sv ----
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs are levels, not pulses
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module mcp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } mcp_sync_s;

    mcp_sync_s st_r;
    mcp_sync_s st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = d;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.sync;

endmodule

// ---- rtl/mcp_pin_drv.sv ----
// Purpose: Per-pin output select, enable and open-drain shaping
// Assumes: Purely combinational; caller registers the results
// Notes:   Open-drain pins drive zero only and float for one
`timescale 1ns/1ps
module mcp_pin_drv #(
    parameter int N = 1
) (
    // Pin configuration
    input  wire logic [N-1:0] latch,
    input  wire logic [N-1:0] func_sel,
    input  wire logic [N-1:0] func_val,
    input  wire logic [N-1:0] dir,
    input  wire logic [N-1:0] ode,
    // Pin drive
    output logic      [N-1:0] pin_val,
    output logic      [N-1:0] pin_oe
);

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            logic level;
            assign level      = func_sel[i] ? func_val[i] : latch[i];
            // Open drain never drives high, so a wired bus is safe
            assign pin_val[i] = ode[i] ? 1'b0 : level;
            assign pin_oe[i]  = ode[i] ? (dir[i] & ~level) : dir[i];
        end
    endgenerate

endmodule

// ---- rtl/mcp_ports.sv ----
// Purpose: Bus-control, chip-select and serial pin ports with function select
// Assumes: Single clock; pins and boot straps are asynchronous and synchronised here
// Notes:   Pin outputs are registered, so they lag their sources by one cycle
//
// Summary of operation
// - Seven-pin bus-control port: pins 0-5 output only, pin 6 bidirectional.
// - After reset pins 1-5 are port outputs, pin 6 a port input.
// - Pin 0 becomes read strobe when boot straps read 01 or 10.
// - Bus-control data bits 0-5 reset to 1; bit 6 latch resets 0.
// - Direction bit 6 sets pin 6 direction; write-only, resets to 0.
// - Function bits 0,1,2,5 select strobes and direction; bit 3 never set.
// - Function bit 4 puts the internal clock on pin 4.
// - Function bit 6 makes pin 6 the wait input; function resets to 01.
// - Four-bit chip-select output port; latch resets to 1011.
// - Chip-select function bit n drives active-low select n on pin n.
// - Chip-select function bits reset to 0, pins are port outputs.
// - Three-bit serial port with per-pin direction register.
// - Serial direction and function reset 0; latches reset to 1.
// - Serial function bits pick clock out, data out/SDA, and SCL roles.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module mcp_ports (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    // Register port
    input  wire logic [mcp_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [mcp_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [mcp_pkg::DATA_W-1:0] reg_rdata,
    // Boot straps
    input  wire logic                       boot_mode_pin_high,
    input  wire logic                       boot_mode_pin_low,
    // Internal bus-control sources and wait request output
    input  wire logic                       mem_rd_n,
    input  wire logic                       write_strobe_low_low_n,
    input  wire logic                       write_strobe_low_upper_n,
    input  wire logic                       mem_rw,
    input  wire logic                       internal_clock,
    output logic                            wait_req_n,
    // Bus-control pins
    output logic      [mcp_pkg::BC_O_W-1:0] busctl_pin_out,
    input  wire logic                       busctl_pin6_in,
    output logic                            busctl_pin6_out,
    output logic                            busctl_pin6_oe,
    // Chip selects
    input  wire logic [mcp_pkg::CS_W-1:0]   chip_select_n,
    output logic      [mcp_pkg::CS_W-1:0]   chipsel_pin_out,
    // Serial unit sources
    input  wire logic                       ser_sck_out,
    input  wire logic                       ser_sdo_sda_out,
    input  wire logic                       ser_scl_out,
    // Serial unit sinks
    output logic                            ser_sck_in,
    output logic                            ser_sda_in,
    output logic                            ser_si_in,
    output logic                            ser_scl_in,
    // Serial pins
    input  wire logic [mcp_pkg::SP_W-1:0]   ser_pin_in,
    output logic      [mcp_pkg::SP_W-1:0]   ser_pin_out,
    output logic      [mcp_pkg::SP_W-1:0]   ser_pin_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [mcp_pkg::BC_W-1:0]   bc_latch;
        logic [mcp_pkg::BC_W-1:0]   bc_func;
        logic                       bc_dir6;
        logic [mcp_pkg::CS_W-1:0]   cs_latch;
        logic [mcp_pkg::CS_W-1:0]   cs_func;
        logic [mcp_pkg::SP_W-1:0]   sp_latch;
        logic [mcp_pkg::SP_W-1:0]   sp_dir;
        logic [mcp_pkg::SP_W-1:0]   sp_func;
        logic [mcp_pkg::SP_W-1:0]   sp_ode;
        logic [1:0]                 strap_cnt;
        logic                       strap_done;
        logic [mcp_pkg::DATA_W-1:0] rdata;
        logic [mcp_pkg::BC_O_W-1:0] bc_out;
        logic                       bc6_out;
        logic                       bc6_oe;
        logic [mcp_pkg::CS_W-1:0]   cs_out;
        logic [mcp_pkg::SP_W-1:0]   sp_out;
        logic [mcp_pkg::SP_W-1:0]   sp_oe;
        logic                       wait_n;
        logic                       sck_in;
        logic                       sda_in;
        logic                       si_in;
        logic                       scl_in;
    } mcp_ports_s;

    mcp_ports_s st_r;
    mcp_ports_s st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers

    logic                     bc6_sync;
    logic [mcp_pkg::SP_W-1:0] sp_sync;
    logic [1:0]               boot_sync;

    mcp_sync #(
        .W (1 + mcp_pkg::SP_W + 2)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       ({busctl_pin6_in, ser_pin_in, boot_mode_pin_high, boot_mode_pin_low}),
        .q       ({bc6_sync, sp_sync, boot_sync})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output select

    logic [mcp_pkg::BC_W-1:0] bc_fsel;
    logic [mcp_pkg::BC_W-1:0] bc_fval;
    logic [mcp_pkg::BC_W-1:0] bc_dir;
    logic [mcp_pkg::BC_W-1:0] bc_val;
    logic [mcp_pkg::BC_W-1:0] bc_oe;
    logic [mcp_pkg::CS_W-1:0] cs_val;
    logic [mcp_pkg::SP_W-1:0] sp_fval;
    logic [mcp_pkg::SP_W-1:0] sp_dir_eff;
    logic [mcp_pkg::SP_W-1:0] sp_val;
    logic [mcp_pkg::SP_W-1:0] sp_oe_c;

    always_comb begin
        // Reserved function bit is ignored, so the pin stays a port output
        bc_fsel                       = st_r.bc_func;
        bc_fsel[mcp_pkg::BC_RSVD_BIT] = 1'b0;
        bc_fsel[mcp_pkg::BC_WAIT_BIT] = 1'b0;
        bc_fval                       = '0;
        bc_fval[mcp_pkg::BC_RD_BIT]   = mem_rd_n;
        bc_fval[mcp_pkg::BC_WLL_BIT]  = write_strobe_low_low_n;
        bc_fval[mcp_pkg::BC_WLU_BIT]  = write_strobe_low_upper_n;
        bc_fval[mcp_pkg::BC_CLK_BIT]  = internal_clock;
        bc_fval[mcp_pkg::BC_RW_BIT]   = mem_rw;
        // Pins 0-5 always drive; pin 6 drives only as a port output
        bc_dir                        = mcp_pkg::BC_OUT_ONLY;
        bc_dir[mcp_pkg::BC_WAIT_BIT]  = st_r.bc_dir6 & ~st_r.bc_func[mcp_pkg::BC_WAIT_BIT];
    end

    always_comb begin
        sp_fval                         = '0;
        sp_fval[mcp_pkg::SP_SCK_BIT]    = ser_sck_out;
        sp_fval[mcp_pkg::SP_SDA_BIT]    = ser_sdo_sda_out;
        sp_fval[mcp_pkg::SP_SCL_BIT]    = ser_scl_out;
        // Clock-out role drives the pin even with direction at input
        sp_dir_eff                      = st_r.sp_dir;
        sp_dir_eff[mcp_pkg::SP_SCK_BIT] = st_r.sp_dir[mcp_pkg::SP_SCK_BIT] |
                                          st_r.sp_func[mcp_pkg::SP_SCK_BIT];
    end

    mcp_pin_drv #(
        .N (mcp_pkg::BC_W)
    ) u_bc_drv (
        .latch    (st_r.bc_latch),
        .func_sel (bc_fsel),
        .func_val (bc_fval),
        .dir      (bc_dir),
        .ode      ({mcp_pkg::BC_W{1'b0}}),
        .pin_val  (bc_val),
        .pin_oe   (bc_oe)
    );

    mcp_pin_drv #(
        .N (mcp_pkg::CS_W)
    ) u_cs_drv (
        .latch    (st_r.cs_latch),
        .func_sel (st_r.cs_func),
        .func_val (chip_select_n),
        .dir      ({mcp_pkg::CS_W{1'b1}}),
        .ode      ({mcp_pkg::CS_W{1'b0}}),
        .pin_val  (cs_val),
        .pin_oe   ()
    );

    mcp_pin_drv #(
        .N (mcp_pkg::SP_W)
    ) u_sp_drv (
        .latch    (st_r.sp_latch),
        .func_sel (st_r.sp_func),
        .func_val (sp_fval),
        .dir      (sp_dir_eff),
        .ode      (st_r.sp_ode),
        .pin_val  (sp_val),
        .pin_oe   (sp_oe_c)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    logic [mcp_pkg::DATA_W-1:0] rd_word;

    always_comb begin
        rd_word = '0;
        unique case (reg_addr)
            mcp_pkg::BC_DATA_OFS: begin
                rd_word[mcp_pkg::BC_W-1:0]   = st_r.bc_latch;
                // Pin 6 reads its latch when direction bit 6 is set, else the pad, even in wait role
                rd_word[mcp_pkg::BC_WAIT_BIT] = st_r.bc_dir6 ?
                    st_r.bc_latch[mcp_pkg::BC_WAIT_BIT] : bc6_sync;
            end
            mcp_pkg::CS_DATA_OFS: begin
                rd_word[mcp_pkg::CS_W-1:0] = st_r.cs_latch;
            end
            mcp_pkg::SP_DATA_OFS: begin
                rd_word[mcp_pkg::SP_W-1:0] = (st_r.sp_dir & st_r.sp_latch) |
                                             (~st_r.sp_dir & sp_sync);
            end
            // Write-only and unmapped offsets read zero
            default: begin
                rd_word = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;

        // Boot strap sampled once, after the synchroniser has filled
        if (!st_r.strap_done) begin
            if (st_r.strap_cnt == mcp_pkg::STRAP_WAIT) begin
                st_nxt.strap_done                    = 1'b1;
                st_nxt.bc_func[mcp_pkg::BC_RD_BIT]   = (boot_sync == mcp_pkg::BOOT_MODE_A) ||
                                                       (boot_sync == mcp_pkg::BOOT_MODE_B);
            end else begin
                st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
            end
        end

        // Register writes; a write in the strap cycle wins
        if (reg_wr) begin
            unique case (reg_addr)
                mcp_pkg::BC_DATA_OFS: begin
                    st_nxt.bc_latch = reg_wdata[mcp_pkg::BC_W-1:0];
                end
                mcp_pkg::BC_DIR_OFS: begin
                    st_nxt.bc_dir6 = reg_wdata[mcp_pkg::BC_WAIT_BIT];
                end
                mcp_pkg::BC_FUNC_OFS: begin
                    st_nxt.bc_func = reg_wdata[mcp_pkg::BC_W-1:0];
                end
                mcp_pkg::CS_DATA_OFS: begin
                    st_nxt.cs_latch = reg_wdata[mcp_pkg::CS_W-1:0];
                end
                mcp_pkg::CS_FUNC_OFS: begin
                    st_nxt.cs_func = reg_wdata[mcp_pkg::CS_W-1:0];
                end
                mcp_pkg::SP_DATA_OFS: begin
                    st_nxt.sp_latch = reg_wdata[mcp_pkg::SP_W-1:0];
                end
                mcp_pkg::SP_ODE_OFS: begin
                    // Only pins 1 and 2 have an open-drain option
                    st_nxt.sp_ode = reg_wdata[mcp_pkg::SP_W-1:0] & mcp_pkg::SP_ODE_MASK;
                end
                mcp_pkg::SP_DIR_OFS: begin
                    st_nxt.sp_dir = reg_wdata[mcp_pkg::SP_W-1:0];
                end
                mcp_pkg::SP_FUNC_OFS: begin
                    st_nxt.sp_func = reg_wdata[mcp_pkg::SP_W-1:0];
                end
                default: begin
                    st_nxt.strap_done = st_nxt.strap_done;
                end
            endcase
        end

        // Read data stands in the cycle after the strobe only
        st_nxt.rdata = reg_rd ? rd_word : '0;

        // Registered pin drive
        st_nxt.bc_out  = bc_val[mcp_pkg::BC_O_W-1:0];
        st_nxt.bc6_out = bc_val[mcp_pkg::BC_WAIT_BIT];
        st_nxt.bc6_oe  = bc_oe[mcp_pkg::BC_WAIT_BIT];
        st_nxt.cs_out  = cs_val;
        st_nxt.sp_out  = sp_val;
        st_nxt.sp_oe   = sp_oe_c;

        // Wait request is inactive high unless pin 6 is in wait role
        st_nxt.wait_n = st_r.bc_func[mcp_pkg::BC_WAIT_BIT] ? bc6_sync : 1'b1;

        // Serial inputs always see the pads; the unit ignores them in output roles
        st_nxt.sck_in = sp_sync[mcp_pkg::SP_SCK_BIT];
        st_nxt.sda_in = sp_sync[mcp_pkg::SP_SDA_BIT];
        st_nxt.si_in  = sp_sync[mcp_pkg::SP_SCL_BIT];
        st_nxt.scl_in = sp_sync[mcp_pkg::SP_SCL_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r            <= '0;
            st_r.bc_latch   <= mcp_pkg::BC_LATCH_RST;
            st_r.bc_func    <= mcp_pkg::BC_FUNC_RST;
            st_r.bc_dir6    <= 1'b0;
            st_r.cs_latch   <= mcp_pkg::CS_LATCH_RST;
            st_r.cs_func    <= mcp_pkg::CS_FUNC_RST;
            st_r.sp_latch   <= mcp_pkg::SP_LATCH_RST;
            st_r.sp_dir     <= mcp_pkg::SP_DIR_RST;
            st_r.sp_func    <= mcp_pkg::SP_FUNC_RST;
            st_r.bc_out     <= mcp_pkg::BC_LATCH_RST[mcp_pkg::BC_O_W-1:0];
            st_r.cs_out     <= mcp_pkg::CS_LATCH_RST;
            st_r.sp_out     <= mcp_pkg::SP_LATCH_RST;
            st_r.wait_n     <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata       = st_r.rdata;
    assign wait_req_n      = st_r.wait_n;
    assign busctl_pin_out  = st_r.bc_out;
    assign busctl_pin6_out = st_r.bc6_out;
    assign busctl_pin6_oe  = st_r.bc6_oe;
    assign chipsel_pin_out = st_r.cs_out;
    assign ser_pin_out     = st_r.sp_out;
    assign ser_pin_oe      = st_r.sp_oe;
    assign ser_sck_in      = st_r.sck_in;
    assign ser_sda_in      = st_r.sda_in;
    assign ser_si_in       = st_r.si_in;
    assign ser_scl_in      = st_r.scl_in;

endmodule

// ---- sim/mcp_far_side.sv ----
// Purpose: Far side of the pins: wait source and serial bus devices
// Assumes: Serial lines carry pull-ups; the memory side drives the wait line
// Notes:   Serial lines resolve as a wired-and of all drivers
`timescale 1ns/1ps
module mcp_far_side (
    // Design pin drive
    input  wire logic       pin6_out,
    input  wire logic       pin6_oe,
    input  wire logic [2:0] ser_out,
    input  wire logic [2:0] ser_oe,
    // Far-side devices
    input  wire logic       wait_drive,
    input  wire logic [2:0] dev_en,
    input  wire logic [2:0] dev_val,
    // Resolved pad levels
    output logic            pin6_level,
    output logic      [2:0] ser_level
);
    // Wait source backs off while the port drives the line
    assign pin6_level = pin6_oe ? pin6_out : wait_drive;
    // Released lines float high; open drain cannot fight a device
    assign ser_level = (~ser_oe | ser_out) & (~dev_en | dev_val);
endmodule

// ---- sim/mcp_ports_chk.sv ----
// Purpose: Port-level checks for the pin ports
// Assumes: Only the top ports are visible
// Notes:   A register write shows on the pins two edges later
`timescale 1ns/1ps
module mcp_ports_chk (
    // Clock, reset and register port
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Sources and pins
    input wire logic       internal_clock,
    input wire logic       ser_sck_out,
    input wire logic [3:0] chip_select_n,
    input wire logic [5:0] busctl_pin_out,
    input wire logic       busctl_pin6_oe,
    input wire logic [3:0] chipsel_pin_out,
    input wire logic [2:0] ser_pin_out,
    input wire logic [2:0] ser_pin_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence wr_s(logic [7:0] a, logic [7:0] m);
        reg_wr && reg_addr == a && (reg_wdata & m) == m;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    wo_read_a: assert property ($past(reg_rd) && $past(reg_addr) inside {8'h1e, 8'h1f, 8'h23,
        8'h25, 8'h26, 8'h27} |-> reg_rdata == 8'h00) else $error("write-only register read back");
    cs_func_a: assert property (wr_s(8'h23, 8'h0f) |-> ##2 chipsel_pin_out == $past(chip_select_n))
        else $error("chip selects not routed");
    clk_out_a: assert property (wr_s(8'h1f, 8'h10) |-> ##2 busctl_pin_out[4] == $past(internal_clock))
        else $error("clock not on pin 4");
    wait_in_a: assert property (wr_s(8'h1f, 8'h40) |-> ##2 !busctl_pin6_oe)
        else $error("pin 6 driven in wait role");
    od_low_a: assert property (wr_s(8'h25, 8'h06) |-> ##2 ser_pin_out[2:1] == 2'b00)
        else $error("open drain drives high");
    sck_out_a: assert property (wr_s(8'h27, 8'h01) |-> ##2 ser_pin_oe[0] &&
        ser_pin_out[0] == $past(ser_sck_out)) else $error("serial clock not driven");
    rst_vals_a: assert property (disable iff (1'b0) !rst_n |-> busctl_pin_out == 6'h3f &&
        chipsel_pin_out == 4'hb && !busctl_pin6_oe) else $error("bad pin reset state");
    rst_ser_a: assert property (disable iff (1'b0) !rst_n |-> ser_pin_oe == 3'h0 && ser_pin_out == 3'h7)
        else $error("bad serial reset state");
endmodule
bind mcp_ports mcp_ports_chk u_chk (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .internal_clock, .ser_sck_out, .chip_select_n, .busctl_pin_out, .busctl_pin6_oe, .chipsel_pin_out,
    .ser_pin_out, .ser_pin_oe);

// ---- sim/mcp_ports_tb_top.sv ----
// Purpose: Register-driven test of the pin ports
// Assumes: Boot straps read 01, then 10 after a second reset; pin 0 starts as read strobe
// Notes:   Fixed settle counts follow the one-edge pin register lag
`timescale 1ns/1ps
module mcp_ports_tb_top;
    logic       sys_clk   = 1'b0;
    // Starts high so the time-zero drop is a real reset edge
    logic       rst_n     = 1'b1;
    logic [1:0] boot      = 2'b01;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [7:0] reg_rdata;
    logic [4:0] src       = 5'h1f;
    logic       wait_drv  = 1'b1;
    logic       wait_n, p6_out, p6_oe, p6_lvl;
    logic [5:0] bc_out;
    logic [3:0] cs_n      = 4'hf;
    logic [3:0] cs_out, sinks;
    logic [2:0] ser_src   = 3'h7;
    logic [2:0] dev_en    = 3'h0;
    logic [2:0] dev_val   = 3'h7;
    logic [2:0] sp_out, sp_oe, sp_lvl;
    logic [7:0] wo [7]    = '{8'h1e, 8'h1f, 8'h23, 8'h25, 8'h26, 8'h27, 8'h30};
    int         num_errors = 0;
    int         tests_run  = 0;
    always #2.5 sys_clk = ~sys_clk;
    mcp_ports u_dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .boot_mode_pin_high(boot[1]), .boot_mode_pin_low(boot[0]), .mem_rd_n(src[0]), .write_strobe_low_low_n(src[1]),
        .write_strobe_low_upper_n(src[2]), .mem_rw(src[4]), .internal_clock(src[3]), .wait_req_n(wait_n),
        .busctl_pin_out(bc_out), .busctl_pin6_in(p6_lvl), .busctl_pin6_out(p6_out), .busctl_pin6_oe(p6_oe),
        .chip_select_n(cs_n), .chipsel_pin_out(cs_out), .ser_sck_out(ser_src[0]), .ser_sdo_sda_out(ser_src[1]),
        .ser_scl_out(ser_src[2]), .ser_sck_in(sinks[3]), .ser_sda_in(sinks[2]), .ser_si_in(sinks[1]),
        .ser_scl_in(sinks[0]), .ser_pin_in(sp_lvl), .ser_pin_out(sp_out), .ser_pin_oe(sp_oe));
    mcp_far_side u_far (.pin6_out(p6_out), .pin6_oe(p6_oe), .ser_out(sp_out), .ser_oe(sp_oe),
        .wait_drive(wait_drv), .dev_en, .dev_val, .pin6_level(p6_lvl), .ser_level(sp_lvl));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp, string nm);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, exp, reg_rdata);
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        rst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(4);
        @(posedge sys_clk);
        src <= 5'h1e;
        settle(1);
        chk("strap pins", 8'h3e, {2'b00, bc_out});
        rd(8'h1c, 8'h7f, "bc data");
        rd(8'h20, 8'h0b, "cs data");
        rd(8'h24, 8'h07, "sp data");
        foreach (wo[i]) rd(wo[i], 8'h00, "write only");
        @(posedge sys_clk);
        cs_n <= 4'h5;
        wr(8'h23, 8'h0f);
        settle(1);
        chk("cs select", 8'h05, {4'h0, cs_out});
        wr(8'h23, 8'h00);
        wr(8'h20, 8'h06);
        settle(1);
        chk("cs port", 8'h06, {4'h0, cs_out});
        @(posedge sys_clk);
        src <= 5'h00;
        // Reserved bit 3 stays clear, as software must keep it
        wr(8'h1f, 8'h37);
        settle(1);
        chk("bc func", 8'h08, {2'b00, bc_out});
        wr(8'h1e, 8'h40);
        wr(8'h1f, 8'h00);
        wr(8'h1c, 8'h40);
        settle(1);
        chk("pin6 drive", 8'h03, {6'h00, p6_out, p6_oe});
        rd(8'h1c, 8'h40, "bc readback");
        @(posedge sys_clk);
        wait_drv <= 1'b0;
        wr(8'h1f, 8'h40);
        settle(5);
        chk("wait in", 8'h00, {6'h00, wait_n, p6_oe});
        wr(8'h26, 8'h07);
        wr(8'h24, 8'h05);
        settle(1);
        chk("sp out", 8'h75, {1'b0, sp_oe, 1'b0, sp_out});
        wr(8'h24, 8'h03);
        wr(8'h25, 8'h06);
        settle(1);
        chk("sp od", 8'h51, {1'b0, sp_oe, 1'b0, sp_out});
        // All three function roles; sources differ from the latches
        @(posedge sys_clk);
        ser_src <= 3'h4;
        wr(8'h27, 8'h07);
        settle(1);
        chk("sp func", 8'h30, {1'b0, sp_oe, 1'b0, sp_out});
        @(posedge sys_clk);
        dev_en <= 3'h4;
        dev_val <= 3'h0;
        wr(8'h27, 8'h00);
        wr(8'h26, 8'h00);
        settle(4);
        chk("serial in", 8'h0c, {4'h0, sinks});
        rd(8'h24, 8'h03, "sp pads");
        // Second reset with the other legal strap code
        @(posedge sys_clk);
        rst_n <= 1'b0;
        boot <= 2'b10;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(5);
        chk("strap 10", 8'h3e, {2'b00, bc_out});
        report_and_stop();
    end
endmodule
